// ### src/sac_conv_ctrl.sv
// conversion sequencing, sar register and three-state result bus
//
// How it works
// - 12-bit variant converts in 14 master clocks
// - 10-bit variant converts in 12 master clocks
// - master clock ignored outside a conversion
// - busy rises on start fall, stays high
// - busy falls after result reaches output register
// - back to track just before busy falls
// - start still low at busy fall: sleep
// - result bus driven only during select and read
// - bus bits 0..9 or 0..11 per variant
// - select and read and-combined, may stay low
// - start falling edge: hold, begin converting
// - wake on start rise, 1 us wake-up
// - result coded straight binary from zero
`timescale 1ns/1ps
module sac_conv_ctrl import sac_pkg::*; #(
    parameter bit WIDE_VARIANT = 1'b1   // 1: 12-bit part, 0: 10-bit part
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // host strobes
    input  wire logic        CONVERSION_START_N,
    input  wire logic        CS_N,
    input  wire logic        RD_N,
    // master clock and analog comparator
    input  wire logic        MASTER_CLK,
    input  wire logic        COMP_IN,
    // status
    output logic             BUSY,
    output logic             HOLD,
    output logic             SLEEP,
    output logic             MCLK_GATE,
    // sar dac drive
    output logic [11:0]      DAC_CODE,
    // three-state result bus
    output logic [11:0]      RESULT_BUS_O,
    output logic [11:0]      RESULT_BUS_OE
);
    localparam logic [3:0]  N_BITS = WIDE_VARIANT ? BITS_WIDE : BITS_NARROW;
    localparam logic [3:0]  N_CYC  = WIDE_VARIANT ? CYC_WIDE : CYC_NARROW;
    localparam logic [11:0] N_MASK = WIDE_VARIANT ? MASK_WIDE : MASK_NARROW;

    sac_pins_s   pin_raw;          // pins as they arrive
    sac_pins_s   sync1;            // first stage, read only by sync2
    sac_pins_s   sync2;            // safe to use
    sac_pins_s   pin_q;            // previous safe sample for edges
    sac_state_e  state;            // controller state
    logic [3:0]  cyc;              // master clocks counted
    logic [3:0]  bit_idx;          // current trial bit
    logic [11:0] sar;              // successive approximation register
    logic [4:0]  wake_cnt;         // wake-up timer
    logic        pushed;           // this conversion handed to fifo
    logic        conv_fall;
    logic        conv_rise;
    logic        mclk_rise;
    logic        read_act;         // select and read both low
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [11:0] fifo_out_data;

    assign pin_raw = '{conv_n: CONVERSION_START_N, cs_n: CS_N, rd_n: RD_N,
                       mclk: MASTER_CLK, comp: COMP_IN};

    // two-flop synchroniser, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
            always_ff @(posedge REF_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                    pin_q[gi] <= 1'b1;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    pin_q[gi] <= sync2[gi];
                end
            end
        end
    endgenerate

    assign conv_fall = pin_q.conv_n && !sync2.conv_n;
    assign conv_rise = !pin_q.conv_n && sync2.conv_n;
    // master clock only reaches the sequencer while converting
    assign MCLK_GATE = (state == ST_CONV);
    assign mclk_rise = MCLK_GATE && !pin_q.mclk && sync2.mclk;
    // one and-gate, either strobe may be tied low
    assign read_act  = !sync2.cs_n && !sync2.rd_n;

    // controller: start, count, hand over, track, sleep, wake
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state    <= ST_IDLE;
            BUSY     <= 1'b0;
            HOLD     <= 1'b0;
            SLEEP    <= 1'b0;
            cyc      <= 4'h0;
            pushed   <= 1'b0;
            wake_cnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    // falling start: sample held, busy up
                    if (conv_fall) begin
                        state <= ST_CONV;
                        BUSY  <= 1'b1;
                        HOLD  <= 1'b1;
                        cyc   <= 4'h0;
                    end
                end
                ST_CONV: begin
                    // fixed count of master clocks per conversion
                    if (mclk_rise) begin
                        cyc <= cyc + 4'h1;
                        if (cyc == N_CYC - 4'h1) begin
                            state  <= ST_DONE;
                            pushed <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    if (fifo_in_valid && fifo_in_ready) begin
                        pushed <= 1'b1;
                    end
                    // result drained into output register: release track first
                    if (pushed && !fifo_out_valid && HOLD) begin
                        HOLD <= 1'b0;
                    end else if (!HOLD) begin
                        BUSY  <= 1'b0;
                        // start still low: sleep on busy fall
                        if (!sync2.conv_n) begin
                            state <= ST_SLEEP;
                            SLEEP <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_SLEEP: begin
                    // rising start wakes the part
                    if (conv_rise) begin
                        state    <= ST_WAKE;
                        wake_cnt <= 5'h00;
                    end
                end
                ST_WAKE: begin
                    // starts during wake-up are not taken
                    wake_cnt <= wake_cnt + 5'h01;
                    if (wake_cnt == WAKE_CYC - 5'h01) begin
                        state <= ST_IDLE;
                        SLEEP <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // sar trials: msb first, keep bit when input is at or above trial level
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sar     <= 12'h000;
            bit_idx <= 4'h0;
        end else if (state == ST_IDLE && conv_fall) begin
            bit_idx <= N_BITS - 4'h1;
            sar     <= 12'h000;
            sar[N_BITS - 4'h1] <= 1'b1;
        end else if (mclk_rise && cyc < N_BITS) begin
            // straight binary, zero at the bottom of range
            if (!sync2.comp) begin
                sar[bit_idx] <= 1'b0;
            end
            if (bit_idx != 4'h0) begin
                sar[bit_idx - 4'h1] <= 1'b1;
                bit_idx <= bit_idx - 4'h1;
            end
        end
    end

    assign DAC_CODE      = sar;
    assign fifo_in_valid = (state == ST_DONE) && !pushed;
    // stall one cycle as a read opens, so the word never changes under its first edge
    assign fifo_out_ready = !(read_act && (pin_q.cs_n || pin_q.rd_n));

    sac_fifo #(
        .WIDTH (RES_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (sar & N_MASK),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // output register only changes on a new completed result
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RESULT_BUS_O <= RESULT_RESET;
        end else if (fifo_out_valid && fifo_out_ready) begin
            RESULT_BUS_O <= fifo_out_data;
        end
    end

    // bus enable per bit, upper bits never driven on the narrow part
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RESULT_BUS_OE <= 12'h000;
        end else begin
            RESULT_BUS_OE <= read_act ? N_MASK : 12'h000;
        end
    end

    // checks
    a_busy_on_start: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state == ST_IDLE && conv_fall) |=> BUSY && HOLD)
        else $error("busy or hold not raised after start");
    a_busy_through_conv: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state == ST_CONV) |-> BUSY)
        else $error("busy low during conversion");
    a_cycle_count_exact: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $fell(state == ST_CONV) |-> (cyc == N_CYC))
        else $error("conversion ended after wrong master clock count");
    // the last count lands on the edge that leaves conversion, so that one cycle is skipped
    a_gate_only_conv: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state != ST_CONV && $past(state) != ST_CONV) |-> !MCLK_GATE && $stable(cyc))
        else $error("master clock counted outside conversion");
    a_track_before_busy: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $fell(BUSY) |-> !HOLD && $past(BUSY) && !$past(HOLD))
        else $error("track not restored before busy fall");
    a_busy_after_load: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $fell(BUSY) |-> !fifo_out_valid && pushed)
        else $error("busy fell before result loaded");
    a_sleep_on_fall: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ($fell(BUSY) && !$past(sync2.conv_n)) |-> SLEEP && state == ST_SLEEP)
        else $error("no sleep with start held low");
    // twenty wake cycles: first one, nineteen later the last, then awake
    a_wake_time: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state == ST_SLEEP && conv_rise) |=> (state == ST_WAKE && wake_cnt == 5'h00) ##19
        (state == ST_WAKE && SLEEP) ##1 (!SLEEP && state == ST_IDLE))
        else $error("wake-up time not kept");
    a_sleep_in_wake: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (state == ST_SLEEP || state == ST_WAKE) |-> SLEEP)
        else $error("sleep flag low while asleep or waking");
    a_bus_enable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ##1 (RESULT_BUS_OE == ($past(read_act) ? N_MASK : 12'h000)))
        else $error("bus enable does not follow select and read");
    a_result_holds: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !$past(fifo_out_valid) |-> $stable(RESULT_BUS_O))
        else $error("output register changed without new result");
endmodule

// ### src/sac_pkg.sv
// shared constants, states and pin bundle for the sar conversion controller
package sac_pkg;
    localparam int          RES_WIDTH     = 12;          // widest result (12-bit variant)
    localparam int          FIFO_DEPTH    = 32;          // result words buffered
    localparam logic [3:0]  BITS_WIDE     = 4'hC;        // 12 trial bits
    localparam logic [3:0]  BITS_NARROW   = 4'hA;        // 10 trial bits
    localparam logic [3:0]  CYC_WIDE      = 4'hE;        // 14 master clocks
    localparam logic [3:0]  CYC_NARROW    = 4'hC;        // 12 master clocks
    localparam logic [11:0] MASK_WIDE     = 12'hFFF;     // bus bits 0..11
    localparam logic [11:0] MASK_NARROW   = 12'h3FF;     // bus bits 0..9
    localparam logic [11:0] RESULT_RESET  = 12'h000;     // output register at reset
    localparam int          REF_CLK_NS    = 50;          // 20 MHz reference clock
    localparam int          WAKE_NS       = 1000;        // wake-up time after sleep
    localparam logic [4:0]  WAKE_CYC      = 5'((WAKE_NS + REF_CLK_NS - 1) / REF_CLK_NS);
    localparam int          PIN_CNT       = 5;           // synchronised pins

    // controller states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CONV  = 5'b00010,
        ST_DONE  = 5'b00100,
        ST_SLEEP = 5'b01000,
        ST_WAKE  = 5'b10000
    } sac_state_e;

    // asynchronous pins sampled together
    typedef struct packed {
        logic conv_n;   // conversion start, active low
        logic cs_n;     // select, active low
        logic rd_n;     // read, active low
        logic mclk;     // external master clock
        logic comp;     // comparator decision
    } sac_pins_s;
endpackage

// ### src/sac_fifo.sv
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
module sac_fifo import sac_pkg::*; #(
    parameter int WIDTH = RES_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // flop storage
    logic [AW:0]      wr_ptr;        // extra bit tells full from empty
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // honest flags from pointer compare
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ### verification/sac_analog_model.sv
// stand-in for the analog front end: sampler and comparator
`timescale 1ns/1ps
module sac_analog_model import sac_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // device side
    input  wire logic        hold,
    input  wire logic [11:0] dac_code,
    output logic             comp,
    // stimulus side
    input  wire logic [11:0] level
);
    logic [11:0] held;  // level frozen while in hold

    // sampler tracks while hold is low, so the code cannot move mid-conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= RESULT_RESET;
        end else if (!hold) begin
            held <= level;
        end
    end

    // comparator: high once the held level reaches the trial code
    assign comp = (held >= dac_code);
endmodule

// ### verification/testbench.sv
// self-checking bench, both variants side by side
`timescale 1ns/1ps
module testbench import sac_pkg::*; ();
    logic        ref_clk = 1'b0;  // 20 MHz clock
    logic        rstn    = 1'b0;  // reset, active low
    logic        conv_n  = 1'b1;  // start strobe
    logic        cs_n    = 1'b1;  // select strobe
    logic        rd_n    = 1'b1;  // read strobe
    logic        mclk    = 1'b0;  // master clock, free running
    logic [1:0]  busy, hold, sleep, gate, comp;  // index 0 wide, 1 narrow
    logic [11:0] dac [2];
    logic [11:0] bus_o [2];
    logic [11:0] bus_oe [2];
    logic [11:0] level [2];
    logic [2:0]  msh = 3'h0;      // bench copy of the master clock sync
    int          mcnt [2];        // master clock rises seen while gated
    int          fails = 0;
    int          compares = 0;

    // clocks: master clock at 8 periods, unrelated phase
    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        #13;
        forever #200 mclk = ~mclk;
    end

    for (genvar v = 0; v < 2; v++) begin : g_var
        sac_conv_ctrl #(.WIDE_VARIANT(v == 0)) sac_conv_ctrl_inst (
            .REF_CLK(ref_clk), .RSTN(rstn), .CONVERSION_START_N(conv_n), .CS_N(cs_n), .RD_N(rd_n),
            .MASTER_CLK(mclk), .COMP_IN(comp[v]), .BUSY(busy[v]), .HOLD(hold[v]), .SLEEP(sleep[v]),
            .MCLK_GATE(gate[v]), .DAC_CODE(dac[v]), .RESULT_BUS_O(bus_o[v]), .RESULT_BUS_OE(bus_oe[v]));
        sac_analog_model sac_analog_model_inst (
            .clk(ref_clk), .rst_n(rstn), .hold(hold[v]), .dac_code(dac[v]), .comp(comp[v]),
            .level(level[v]));
    end

    // count synced master clock rises while the gate admits them
    always @(posedge ref_clk) begin
        msh <= {msh[1:0], mclk};
        for (int v = 0; v < 2; v++)
            if (gate[v] === 1'b1 && msh[1] && !msh[2]) mcnt[v]++;
    end

    function automatic logic [11:0] mask_of(int v);
        return v == 0 ? MASK_WIDE : MASK_NARROW;
    endfunction

    function automatic int cyc_of(int v);
        return v == 0 ? int'(CYC_WIDE) : int'(CYC_NARROW);
    endfunction

    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one conversion; stay_low keeps the start strobe down to force sleep
    task automatic convert(input logic [11:0] val, input bit stay_low);
        int         t;
        bit [1:0]   done;
        logic [1:0] hprev;
        @(posedge ref_clk);
        for (int v = 0; v < 2; v++) level[v] <= val & mask_of(v);
        mcnt[0] = 0;
        mcnt[1] = 0;
        // start just after a master clock rise, away from the gate edges
        @(posedge mclk);
        @(posedge ref_clk);
        conv_n <= 1'b0;
        t = 0;
        while (busy !== 2'b11 && t < 10) begin
            @(negedge ref_clk);
            t++;
        end
        check("busy_rise", {10'h0, busy}, 12'h003);
        check("hold_set", {10'h0, hold}, 12'h003);
        if (!stay_low) begin
            @(posedge ref_clk);
            conv_n <= 1'b1;
        end
        done = 2'b00;
        hprev = hold;
        t = 0;
        while (done !== 2'b11 && t < 300) begin
            @(negedge ref_clk);
            t++;
            for (int v = 0; v < 2; v++) if (!done[v] && busy[v] !== 1'b1) begin
                done[v] = 1'b1;
                check("mclk_count", 12'(mcnt[v]), 12'(cyc_of(v)));
                check("result", bus_o[v], val & mask_of(v));
                check("dac_final", dac[v], val & mask_of(v));
                check("hold_first", {11'h0, hprev[v]}, 12'h000);
                check("sleep_entry", {11'h0, sleep[v]}, {11'h0, stay_low});
                check("gate_off", {11'h0, gate[v]}, 12'h000);
                if (cs_n === 1'b0 && rd_n === 1'b0) check("tied_oe", bus_oe[v], mask_of(v));
            end
            hprev = hold;
        end
        check("busy_fall", {10'h0, busy}, 12'h000);
        if (stay_low) begin
            @(posedge ref_clk);
            conv_n <= 1'b1;
            repeat (12) @(negedge ref_clk);
            check("waking", {10'h0, sleep}, 12'h003);
            repeat (18) @(negedge ref_clk);
            check("awake", {10'h0, sleep}, 12'h000);
        end
    endtask

    // reads with each strobe pairing; only both low opens the bus
    task automatic read_back(input logic [11:0] val);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            cs_n <= k[0];
            rd_n <= k[1];
            repeat (5) @(negedge ref_clk);
            for (int v = 0; v < 2; v++) begin
                check("bus_oe", bus_oe[v], k == 0 ? mask_of(v) : 12'h000);
                check("bus_data", bus_o[v], val & mask_of(v));
            end
        end
        @(posedge ref_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(negedge ref_clk);
        check("bus_off", bus_oe[0] | bus_oe[1], 12'h000);
    endtask

    initial begin
        logic [11:0] val;
        level[0] = 12'h000;
        level[1] = 12'h000;
        mcnt[0] = 0;
        mcnt[1] = 0;
        void'($urandom(32'hF379));
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        check("reset_busy", {10'h0, busy}, 12'h000);
        check("reset_oe", bus_oe[0] | bus_oe[1], 12'h000);
        $display("test reset done");
        convert(12'h000, 1'b0);
        read_back(12'h000);
        $display("test zero scale done");
        convert(12'hFFF, 1'b1);
        read_back(12'hFFF);
        $display("test full scale with sleep done");
        for (int i = 0; i < 6; i++) begin
            val = 12'($urandom);
            convert(val, i[0]);
            read_back(val);
            $display("test random %0d done", i);
        end
        // strobes tied low: result must be on the bus by busy fall
        @(posedge ref_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        val = 12'($urandom);
        convert(val, 1'b0);
        read_back(val);
        $display("test tied strobes done");
        wrap_up;
    end

    // watchdog, far beyond the roughly 1500 cycles the tests need
    initial begin
        #1000000;
        fails++;
        wrap_up;
    end
endmodule
